// ==== logic/esq_map.svh ====
/*
  Register offsets, field positions, reset values and widths of the
  exposure status and sequencer mode register slice.
  Assumes a 9-bit word address from the serial configuration port.
*/
`ifndef ESQ_MAP_SVH
`define ESQ_MAP_SVH

`define ESQ_ADDR_W           9
`define ESQ_DATA_W           16

`define ESQ_OFS_PIX_LOW      9'h0b8
`define ESQ_OFS_PIX_HIGH     9'h0b9
`define ESQ_OFS_AVG_LOCK     9'h0ba
`define ESQ_OFS_EXP_RB       9'h0bb
`define ESQ_OFS_GAIN_RB      9'h0bc
`define ESQ_OFS_RSVD_STAT    9'h0bd
`define ESQ_OFS_MODE         9'h0c0
`define ESQ_OFS_DELAY_CFG    9'h0c1

`define ESQ_PIX_W            19
`define ESQ_PIX_LOW_MSB      15
`define ESQ_PIX_HIGH_MSB     2
`define ESQ_AVG_W            10
`define ESQ_LOCK_BIT         12
`define ESQ_AMP1_LSB         0
`define ESQ_AMP2_LSB         2
`define ESQ_DGAIN_LSB        4
`define ESQ_DGAIN_W          12

`define ESQ_MODE_ENABLE      0
`define ESQ_MODE_ROLLING     1
`define ESQ_MODE_TRIGGERED   4
`define ESQ_MODE_SLAVE       5
`define ESQ_MODE_DELAY_EN    6
`define ESQ_MODE_SUBSAMPLE   7
`define ESQ_MODE_BINNING     8
`define ESQ_MODE_W           9
`define ESQ_MODE_RESET       9'h000

`define ESQ_DLY_XLEN_MSB     7
`define ESQ_DLY_LEN_LSB      8
`define ESQ_DLY_LEN_W        8
`define ESQ_DELAY_RESET      16'h0000
`define ESQ_STATUS_RESET     16'h0000

`endif

// ==== logic/esq_pkg.sv ====
/*
  Types shared by the register slice and its readout delay timer.
  Assumes esq_map.svh is on the include path.
*/
`include "esq_map.svh"

package esq_pkg;

  typedef logic [`ESQ_ADDR_W-1:0] esq_addr_t;
  typedef logic [`ESQ_DATA_W-1:0] esq_word_t;

  // Values produced by the exposure control loop
  typedef struct packed {
    logic [`ESQ_PIX_W-1:0]   pixel_count;
    logic [`ESQ_AVG_W-1:0]   average;
    logic                    locked;
    logic [15:0]             exposure;
    logic [1:0]              analog_amp_first_setting;
    logic [1:0]              analog_amp_second_setting;
    logic [`ESQ_DGAIN_W-1:0] digital_gain;
  } esq_status_s;

  // Mode as seen by the sequencer, already qualified by shutter type
  typedef struct packed {
    logic enable;
    logic rolling;
    logic triggered;
    logic slave;
    logic delay_en;
    logic subsample;
    logic binning;
  } esq_mode_s;

  typedef enum logic {DLY_IDLE, DLY_WAIT} esq_dly_e;

endpackage

// ==== logic/esq_readout_delay.sv ====
/*
  Optional delay between the end of the row overhead phase and the
  start of pixel readout.
  Assumes row_overhead_end is a one-cycle pulse on clk; pulses that
  arrive while a delay is running are ignored.
*/
`timescale 1ns/1ps
`include "esq_map.svh"

module esq_readout_delay
  import esq_pkg::*;
#(
  parameter int LEN_W = `ESQ_DLY_LEN_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             delay_en,
  input  wire logic [LEN_W-1:0] delay_len,
  input  wire logic             row_overhead_end,
  output logic                  readout_start,
  output logic                  delay_busy
);

  esq_dly_e         st_q;
  logic [LEN_W-1:0] cnt_q;
  logic             start_q;

  // A zero length acts as no delay so a readout is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= DLY_IDLE;
      cnt_q   <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (st_q)
        DLY_IDLE: begin
          if (row_overhead_end) begin
            if (!delay_en || delay_len == '0) begin
              start_q <= 1'b1;
            end else begin
              cnt_q <= delay_len;
              st_q  <= DLY_WAIT;
            end
          end
        end
        DLY_WAIT: begin
          if (cnt_q == LEN_W'(1)) begin
            start_q <= 1'b1;
            st_q    <= DLY_IDLE;
          end else begin
            cnt_q <= cnt_q - LEN_W'(1);
          end
        end
      endcase
    end
  end

  assign readout_start = start_q;
  assign delay_busy    = (st_q == DLY_WAIT);

  AST_NO_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == DLY_IDLE && row_overhead_end && !delay_en)
      |=> readout_start)
    else $error("readout did not start one cycle after row overhead");

  AST_DELAY_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == DLY_IDLE && row_overhead_end && delay_en && delay_len == 8'h02)
      |=> !readout_start [*2] ##1 readout_start)
    else $error("readout delay length does not match the field");

  COV_DELAYED: cover property (@(posedge clk) disable iff (!rst_n)
    delay_busy ##1 readout_start);

endmodule

// ==== logic/esq_regs.sv ====
/*
  Exposure status readback and sequencer mode registers.
  Assumes the serial configuration port has already been decoded into
  word strobes on clk; status values come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "esq_map.svh"

module esq_regs
  import esq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire esq_addr_t   reg_addr,
  input  wire esq_word_t   reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output esq_word_t        reg_rdata,
  output logic             reg_rvalid,
  input  wire esq_status_s loop_status,
  input  wire logic        loop_status_upd,
  input  wire logic        row_overhead_end,
  output esq_mode_s        seq_mode,
  output logic [7:0]       rs_x_length,
  output logic             readout_start,
  output logic             delay_busy
);

  logic [1:0]             rst_sync_q;
  logic                   rst_n;
  esq_status_s            status_q;
  logic [`ESQ_MODE_W-1:0] mode_q;
  esq_word_t              delay_cfg_q;
  esq_mode_s              mode_out_q;
  esq_mode_s              mode_out_d;
  esq_word_t              rdata_q;
  logic                   rvalid_q;

  function automatic logic hit(input esq_addr_t a, input esq_addr_t ofs);
    return a == ofs;
  endfunction

  // Release is synchronous so that no register leaves reset mid-cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Writes never reach this copy; only the loop refreshes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (loop_status_upd) begin
      status_q <= loop_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `ESQ_MODE_RESET;
    end else if (reg_wr && hit(reg_addr, `ESQ_OFS_MODE)) begin
      mode_q <= reg_wdata[`ESQ_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cfg_q <= `ESQ_DELAY_RESET;
    end else if (reg_wr && hit(reg_addr, `ESQ_OFS_DELAY_CFG)) begin
      delay_cfg_q <= reg_wdata;
    end
  end

  // Triggered and slave selections are ignored in rolling shutter
  always_comb begin
    mode_out_d.enable    = mode_q[`ESQ_MODE_ENABLE];
    mode_out_d.rolling   = mode_q[`ESQ_MODE_ROLLING];
    mode_out_d.triggered = mode_q[`ESQ_MODE_TRIGGERED] &
                           ~mode_q[`ESQ_MODE_ROLLING];
    mode_out_d.slave     = mode_q[`ESQ_MODE_SLAVE] &
                           ~mode_q[`ESQ_MODE_ROLLING];
    mode_out_d.delay_en  = mode_q[`ESQ_MODE_DELAY_EN];
    mode_out_d.subsample = mode_q[`ESQ_MODE_SUBSAMPLE];
    mode_out_d.binning   = mode_q[`ESQ_MODE_BINNING];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_out_q <= '0;
    end else begin
      mode_out_q <= mode_out_d;
    end
  end

  assign seq_mode    = mode_out_q;
  assign rs_x_length = delay_cfg_q[`ESQ_DLY_XLEN_MSB:0];

  function automatic esq_word_t read_mux(input esq_addr_t a);
    esq_word_t w;
    w = '0;
    if (hit(a, `ESQ_OFS_PIX_LOW)) begin
      w = status_q.pixel_count[`ESQ_PIX_LOW_MSB:0];
    end else if (hit(a, `ESQ_OFS_PIX_HIGH)) begin
      w[`ESQ_PIX_HIGH_MSB:0] =
        status_q.pixel_count[`ESQ_PIX_W-1:`ESQ_PIX_LOW_MSB+1];
    end else if (hit(a, `ESQ_OFS_AVG_LOCK)) begin
      w[`ESQ_AVG_W-1:0]  = status_q.average;
      w[`ESQ_LOCK_BIT]   = status_q.locked;
    end else if (hit(a, `ESQ_OFS_EXP_RB)) begin
      w = status_q.exposure;
    end else if (hit(a, `ESQ_OFS_GAIN_RB)) begin
      w[`ESQ_AMP1_LSB+:2] = status_q.analog_amp_first_setting;
      w[`ESQ_AMP2_LSB+:2] = status_q.analog_amp_second_setting;
      w[`ESQ_DGAIN_LSB+:`ESQ_DGAIN_W] = status_q.digital_gain;
    end else if (hit(a, `ESQ_OFS_RSVD_STAT)) begin
      w = `ESQ_STATUS_RESET;
    end else if (hit(a, `ESQ_OFS_MODE)) begin
      w[`ESQ_MODE_W-1:0] = mode_q;
    end else if (hit(a, `ESQ_OFS_DELAY_CFG)) begin
      w = delay_cfg_q;
    end
    return w;
  endfunction

  // Unmapped addresses read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= read_mux(reg_addr);
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  esq_readout_delay #(
    .LEN_W (`ESQ_DLY_LEN_W)
  ) u_delay (
    .clk              (clk),
    .rst_n            (rst_n),
    .delay_en         (mode_out_q.delay_en),
    .delay_len        (delay_cfg_q[`ESQ_DLY_LEN_LSB+:`ESQ_DLY_LEN_W]),
    .row_overhead_end (row_overhead_end),
    .readout_start    (readout_start),
    .delay_busy       (delay_busy)
  );

  // Read data is built from the copy as it stood at the read edge, so
  // a loop update on that same edge must not be seen in the answer
  AST_PIX_LOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_PIX_LOW)
      |=> reg_rvalid && reg_rdata == $past(status_q.pixel_count[15:0]))
    else $error("pixel count low word mismatch");

  AST_PIX_HIGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_PIX_HIGH)
      |=> reg_rdata == {13'h0000, $past(status_q.pixel_count[18:16])})
    else $error("pixel count high field mismatch");

  AST_AVG_LOCK: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_AVG_LOCK)
      |=> reg_rdata[9:0] == $past(status_q.average) &&
          reg_rdata[12] == $past(status_q.locked) &&
          reg_rdata[15:13] == 3'h0 && reg_rdata[11:10] == 2'h0)
    else $error("average or lock readback mismatch");

  AST_GAIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_GAIN_RB)
      |=> reg_rdata == {$past(status_q.digital_gain),
                        $past(status_q.analog_amp_second_setting),
                        $past(status_q.analog_amp_first_setting)})
    else $error("gain readback mismatch");

  AST_EXP_RB: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_EXP_RB)
      |=> reg_rdata == $past(status_q.exposure))
    else $error("exposure readback mismatch");

  AST_RSVD_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_RSVD_STAT)
      |=> reg_rdata == 16'h0000)
    else $error("reserved status word not zero");

  AST_RVALID: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after the read strobe");

  AST_ENABLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `ESQ_OFS_MODE)
      |=> ##1 seq_mode.enable == $past(reg_wdata[0], 2))
    else $error("enable did not follow the mode write");

  AST_MODE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && hit(reg_addr, `ESQ_OFS_MODE))
      |=> mode_q == $past(mode_q))
    else $error("mode word changed without a write");

  AST_MODE_RB: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_MODE)
      |=> reg_rdata == {7'h00, $past(mode_q)})
    else $error("mode word readback mismatch");

  AST_ROLLING: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_mode.rolling == $past(mode_q[1]))
    else $error("shutter selection does not follow the mode word");

  AST_TRIG_GLOBAL: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_mode.triggered |-> !seq_mode.rolling && $past(mode_q[4]))
    else $error("triggered mode outside global shutter");

  AST_TRIG_FOLLOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(mode_q[1]) |-> seq_mode.triggered == $past(mode_q[4]))
    else $error("triggered mode lost in global shutter");

  AST_SLAVE_GLOBAL: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_mode.slave |-> !seq_mode.rolling && $past(mode_q[5]))
    else $error("slave mode outside global shutter");

  AST_SLAVE_FOLLOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(mode_q[1]) |-> seq_mode.slave == $past(mode_q[5]))
    else $error("slave mode lost in global shutter");

  AST_DELAY_EN: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_mode.delay_en == $past(mode_q[6]))
    else $error("delay enable does not follow the mode word");

  AST_SUB_BIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_mode.subsample == $past(mode_q[7]) &&
    seq_mode.binning == $past(mode_q[8]))
    else $error("subsample or binning does not follow the mode word");

  AST_DLY_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && hit(reg_addr, `ESQ_OFS_DELAY_CFG))
      |=> delay_cfg_q == $past(delay_cfg_q))
    else $error("delay word changed without a write");

  AST_DELAY_RB: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, `ESQ_OFS_DELAY_CFG)
      |=> reg_rdata == $past(delay_cfg_q))
    else $error("delay word readback mismatch");

  AST_RO_STATUS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !loop_status_upd |=> status_q == $past(status_q))
    else $error("status changed without a loop update");

  AST_STATUS_UPD: assert property (
    @(posedge clk) disable iff (!rst_n)
    loop_status_upd |=> status_q == $past(loop_status))
    else $error("status did not take the loop value");

  COV_MODE_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `ESQ_OFS_MODE) ##2 seq_mode.enable);

  COV_STATUS_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `ESQ_OFS_EXP_RB));

  COV_LOCK_READ: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rvalid && reg_rdata[12]);

endmodule

// ==== bench/esq_host.sv ====
/*
  Host on the serial configuration port, already decoded to word
  strobes: one write or read task per transfer.
  Assumes tasks are entered at a falling edge of clk.
*/
`timescale 1ns/1ps

module esq_host
  import esq_pkg::*;
(
  input  wire logic      clk,
  output esq_addr_t      reg_addr,
  output esq_word_t      reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input  wire esq_word_t reg_rdata,
  input  wire logic      reg_rvalid
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse so a stale value never passes
  task automatic wr(input esq_addr_t a, input esq_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge clk);
  endtask

  // ok is set only when the answer came exactly one cycle after
  task automatic rd(input esq_addr_t a, output esq_word_t d,
                    output bit ok);
    int n;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    ok = (n == 0);
    d = reg_rdata;
    @(negedge clk);
  endtask
endmodule

// ==== bench/esq_regs_tb.sv ====
/*
  Self-checking bench for the exposure status and sequencer mode
  registers: status readback table, mode word table, readout delay.
  Assumes esq_map.svh on the include path; inputs change on negedge.
*/
`timescale 1ns/1ps
`include "esq_map.svh"

module esq_regs_tb
  import esq_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  esq_status_s st = '0;
  logic        st_upd = 1'b0;
  logic        roe = 1'b0;
  esq_addr_t   reg_addr;
  esq_word_t   reg_wdata;
  esq_word_t   reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_rvalid;
  esq_mode_s   seq_mode;
  logic [7:0]  rs_x_length;
  logic        readout_start;
  logic        delay_busy;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  esq_word_t   d;
  bit          ok;
  logic [24:0] row;
  logic [6:0]  em;

  localparam logic [24:0] STAT_ROWS [7] = '{
    {9'h0b8, 16'ha5a5}, {9'h0b9, 16'h0005}, {9'h0ba, 16'h12b3},
    {9'h0bb, 16'hbeef}, {9'h0bc, 16'h9c49}, {9'h0bd, 16'h0000},
    {9'h0c5, 16'h0000}};
  localparam logic [8:0] MODE_ROWS [10] = '{9'h001, 9'h002, 9'h010,
    9'h020, 9'h040, 9'h080, 9'h100, 9'h1f1, 9'h1f3, 9'h000};

  always #2.5 clk = ~clk;

  esq_regs dut_u (
    .clk              (clk),
    .reset_n          (reset_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .reg_rvalid       (reg_rvalid),
    .loop_status      (st),
    .loop_status_upd  (st_upd),
    .row_overhead_end (roe),
    .seq_mode         (seq_mode),
    .rs_x_length      (rs_x_length),
    .readout_start    (readout_start),
    .delay_busy       (delay_busy)
  );

  esq_host host_u (
    .clk        (clk),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input esq_addr_t a, input esq_word_t exp);
    host_u.rd(a, d, ok);
    check({15'h0, ok}, 16'h0001);
    check(d, exp);
  endtask

  // Gating of triggered and slave by rolling shutter is the hazard here
  function automatic logic [6:0] exp_mode(input logic [8:0] m);
    return {m[0], m[1], m[4] & ~m[1], m[5] & ~m[1], m[6], m[7], m[8]};
  endfunction

  // Cycles from the overhead pulse to the readout start
  task automatic ro_pulse(output int k);
    roe = 1'b1;
    @(negedge clk);
    roe = 1'b0;
    k = 1;
    while (readout_start !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check({9'h0, seq_mode}, 16'h0000);
    rchk(`ESQ_OFS_MODE, 16'h0000);
    rchk(`ESQ_OFS_GAIN_RB, 16'h0000);
    $display("test reset done");
    st = {19'h5a5a5, 10'h2b3, 1'b1, 16'hbeef, 2'h1, 2'h2, 12'h9c4};
    st_upd = 1'b1;
    @(negedge clk);
    st_upd = 1'b0;
    // Loop values move on without an update; readback must not follow
    st = '0;
    foreach (STAT_ROWS[i]) begin
      row = STAT_ROWS[i];
      rchk(row[24:16], row[15:0]);
    end
    host_u.wr(`ESQ_OFS_EXP_RB, 16'h1234);
    host_u.wr(`ESQ_OFS_PIX_LOW, 16'h0f0f);
    rchk(`ESQ_OFS_EXP_RB, 16'hbeef);
    rchk(`ESQ_OFS_PIX_LOW, 16'ha5a5);
    $display("test status done");
    foreach (MODE_ROWS[i]) begin
      host_u.wr(`ESQ_OFS_MODE, {7'h0, MODE_ROWS[i]});
      repeat (2) @(negedge clk);
      em = exp_mode(MODE_ROWS[i]);
      check(16'(seq_mode[6:5]), 16'(em[6:5]));
      check(16'(seq_mode[4:3]), 16'(em[4:3]));
      check(16'(seq_mode[2:0]), 16'(em[2:0]));
      rchk(`ESQ_OFS_MODE, {7'h0, MODE_ROWS[i]});
    end
    $display("test mode done");
    host_u.wr(`ESQ_OFS_DELAY_CFG, 16'h0205);
    check({8'h0, rs_x_length}, 16'h0005);
    rchk(`ESQ_OFS_DELAY_CFG, 16'h0205);
    host_u.wr(`ESQ_OFS_MODE, 16'h0040);
    repeat (2) @(negedge clk);
    ro_pulse(n);
    check(n[15:0], 16'h0003);
    host_u.wr(`ESQ_OFS_DELAY_CFG, 16'hff05);
    ro_pulse(n);
    check(n[15:0], 16'h0100);
    check({15'h0, delay_busy}, 16'h0000);
    host_u.wr(`ESQ_OFS_MODE, 16'h0000);
    repeat (2) @(negedge clk);
    ro_pulse(n);
    check(n[15:0], 16'h0001);
    $display("test delay done");
    // A second reset mid-run must clear everything the host wrote
    host_u.wr(`ESQ_OFS_MODE, 16'h01f3);
    host_u.wr(`ESQ_OFS_DELAY_CFG, 16'h0307);
    reset_n = 1'b0;
    @(negedge clk);
    check(16'(seq_mode), 16'h0000);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check(16'(seq_mode), 16'h0000);
    check({8'h0, rs_x_length}, 16'h0000);
    rchk(`ESQ_OFS_MODE, 16'h0000);
    rchk(`ESQ_OFS_DELAY_CFG, 16'h0000);
    rchk(`ESQ_OFS_PIX_LOW, 16'h0000);
    $display("test second reset done");
    final_report();
  end
endmodule
